/* rtl/mid_regs.vh */
// Constants for the move instruction decoder: opcodes, nibbles, reset values.
// Assumes a 4-bit core with 8-bit opcodes and 8-bit data memory addresses.
`ifndef MID_REGS_VH
`define MID_REGS_VH
`define MID_NIB_LD_HIGH   4'hc
`define MID_NIB_LD_LOW    4'he
`define MID_NIB_ST_IMM    4'hf
`define MID_OP_TBL_LOW    8'h33
`define MID_OP_TBL_HIGH   8'h32
`define MID_OP_ST_IND     8'h0f
`define MID_OP_ST_INC     8'h1a
`define MID_OP_ST_DEC     8'h1b
`define MID_OP_ST_DIR     8'h3f
`define MID_TP_RST        12'h000
`define MID_NIB_RST       4'h0
`endif

/* rtl/mid_addr_step.v */
// Low address register step unit for post-increment and post-decrement.
// Assumes a 4-bit low register; zero follows from the new nibble, status from the carry or borrow.
module mid_addr_step (
  input  wire [3:0] low_in,
  input  wire       down,
  output wire [3:0] low_out,
  output wire       zero_out,
  output wire       status_out
);
  wire [4:0] sum;
  assign sum = down ? ({1'b0, low_in} - 5'h01) : ({1'b0, low_in} + 5'h01);
  assign low_out    = sum[3:0];
  assign zero_out   = (sum[3:0] == 4'h0);
  // Status is set when no carry or borrow left the nibble.
  assign status_out = ~sum[4];
endmodule // mid_addr_step

/* rtl/mid_decoder.v */
// Decode and execute of the move group: address loads, table reads, stores.
// Assumes the fetch unit presents op_valid with opcode, second byte and ROM
// data already read at table_pointer, and that op_valid waits for op_ready.
`include "mid_regs.vh"
// Functional notes
// - Opcode Ck loads immediate k into the high address register.
// - Opcode Ek loads immediate k into the low address register.
// - Opcode 33 loads the table word low nibble into the accumulator, sets zero and status flags, two cycles.
// - Opcode 32 loads the table word high nibble, then bumps the table pointer, two cycles.
// - Opcode 0F stores the accumulator at the high:low address in one cycle.
// - Opcode 1A stores the accumulator indirect then increments low, zero from new low, status from no carry.
// - Opcode 3F with a second byte stores the accumulator at that address, status set, two cycles.
// - Opcode Fk stores immediate k indirect then increments the low register.
// - Indirect addresses are high register as upper nibble, low as lower.
module mid_decoder (
  input  wire        sys_clk,
  input  wire        rst,
  input  wire        op_valid,
  input  wire [7:0]  opcode,
  input  wire [7:0]  op_arg,
  input  wire [7:0]  rom_data,
  input  wire [3:0]  acc_in,
  output reg         op_ready,
  output reg         op_done,
  output reg         acc_we,
  output reg  [3:0]  acc_out,
  output reg  [3:0]  high_address_register,
  output reg  [3:0]  low_address_register,
  output reg  [11:0] table_pointer,
  output reg         zero_flag,
  output reg         status_flag,
  output reg         mem_we,
  output reg  [7:0]  mem_addr,
  output reg  [3:0]  mem_wdata
);
  localparam ST_IDLE = 2'b01;
  localparam ST_EXEC = 2'b10;

  reg  [1:0] state_r;
  // Copies of the fetch inputs, used by the second cycle of two-cycle ops.
  reg  [7:0] op_r;
  reg  [7:0] arg_r;
  reg  [7:0] rom_r;

  wire [3:0] step_low;
  wire       step_zero;
  wire       step_status;
  wire       take;
  wire       step_down;
  wire [11:0] tp_next;

  // A request is taken only while ready; the busy cycle ignores it.
  assign take      = op_valid && op_ready;
  // The step unit counts down only for the post-decrement store.
  assign step_down = (opcode == `MID_OP_ST_DEC);
  // The pointer wraps at 12 bits; a table must not run past the top.
  assign tp_next   = table_pointer + 12'h001;

  // Second cycle of two-cycle ops is done from latched copies of inputs, except acc_in for the direct store.
  function is_two_cycle;
    input [7:0] op;
    begin
      is_two_cycle = (op == `MID_OP_TBL_LOW) || (op == `MID_OP_TBL_HIGH) ||
                     (op == `MID_OP_ST_DIR);
    end
  endfunction

  // Register-indirect address, high register as the upper nibble.
  function [7:0] ind_addr;
    input [3:0] hi;
    input [3:0] lo;
    begin
      ind_addr = {hi, lo};
    end
  endfunction

  // Picks one nibble of the latched table word.
  function [3:0] tbl_nib;
    input [7:0] word;
    input       upper;
    begin
      tbl_nib = upper ? word[7:4] : word[3:0];
    end
  endfunction

  // True when a nibble is zero; drives the zero flag of table reads.
  function nib_zero;
    input [3:0] nib;
    begin
      nib_zero = (nib == 4'h0);
    end
  endfunction

  mid_addr_step u_step (
    .low_in     (low_address_register),
    .down       (step_down),
    .low_out    (step_low),
    .zero_out   (step_zero),
    .status_out (step_status)
  );

  always @(posedge sys_clk or posedge rst) begin
    // Reset leaves the decoder ready with every strobe low.
    if (rst) begin
      state_r               <= ST_IDLE;
      op_r                  <= 8'h00;
      arg_r                 <= 8'h00;
      rom_r                 <= 8'h00;
      op_ready              <= 1'b1;
      op_done               <= 1'b0;
      acc_we                <= 1'b0;
      acc_out               <= `MID_NIB_RST;
      high_address_register <= `MID_NIB_RST;
      low_address_register  <= `MID_NIB_RST;
      table_pointer         <= `MID_TP_RST;
      zero_flag             <= 1'b0;
      status_flag           <= 1'b0;
      mem_we                <= 1'b0;
      mem_addr              <= 8'h00;
      mem_wdata             <= `MID_NIB_RST;
    end else begin
      // Strobes drop every cycle, so each stands for exactly one cycle.
      op_done <= 1'b0;
      acc_we  <= 1'b0;
      mem_we  <= 1'b0;
      case (state_r)
        ST_IDLE: begin
          if (take) begin
            if (is_two_cycle(opcode)) begin
              // Two-cycle ops hold off the next op for one extra cycle.
              op_r     <= opcode;
              arg_r    <= op_arg;
              rom_r    <= rom_data;
              op_ready <= 1'b0;
              state_r  <= ST_EXEC;
            end else begin
              op_done <= 1'b1;
              case (opcode[7:4])
                `MID_NIB_LD_HIGH: begin
                  high_address_register <= opcode[3:0];
                end
                `MID_NIB_LD_LOW: begin
                  low_address_register <= opcode[3:0];
                end
                `MID_NIB_ST_IMM: begin
                  mem_we               <= 1'b1;
                  mem_addr             <= ind_addr(high_address_register,
                                                   low_address_register);
                  mem_wdata            <= opcode[3:0];
                  low_address_register <= step_low;
                  zero_flag            <= step_zero;
                  status_flag          <= step_status;
                end
                default: begin
                  // Opcodes outside this group only pulse op_done.
                  // Indirect store, one cycle.
                  if (opcode == `MID_OP_ST_IND) begin
                    mem_we      <= 1'b1;
                    mem_addr    <= ind_addr(high_address_register,
                                            low_address_register);
                    mem_wdata   <= acc_in;
                    status_flag <= 1'b1;
                  end
                  if ((opcode == `MID_OP_ST_INC) ||
                      (opcode == `MID_OP_ST_DEC)) begin
                    mem_we               <= 1'b1;
                    mem_addr             <= ind_addr(high_address_register,
                                                     low_address_register);
                    mem_wdata            <= acc_in;
                    low_address_register <= step_low;
                    zero_flag            <= step_zero;
                    status_flag          <= step_status;
                  end
                end
              endcase
            end
          end
        end
        ST_EXEC: begin
          // Works from latched copies; only the direct store reads acc_in.
          op_done  <= 1'b1;
          op_ready <= 1'b1;
          state_r  <= ST_IDLE;
          case (op_r)
            `MID_OP_TBL_LOW: begin
              acc_we      <= 1'b1;
              acc_out     <= tbl_nib(rom_r, 1'b0);
              zero_flag   <= nib_zero(rom_r[3:0]);
              status_flag <= 1'b1;
            end
            `MID_OP_TBL_HIGH: begin
              acc_we        <= 1'b1;
              acc_out       <= tbl_nib(rom_r, 1'b1);
              zero_flag     <= nib_zero(rom_r[7:4]);
              status_flag   <= 1'b1;
              table_pointer <= tp_next;
            end
            default: begin
              mem_we      <= 1'b1;
              mem_addr    <= arg_r;
              mem_wdata   <= acc_in;
              status_flag <= 1'b1;
            end
          endcase
        end
        // A corrupt state code falls back to idle and reopens requests.
        default: begin
          state_r  <= ST_IDLE;
          op_ready <= 1'b1;
        end
      endcase
    end
  end
endmodule // mid_decoder

/* tb/mid_props.sv */
// Checker for the move decoder, bound to mid_decoder by the bench.
// Assumes one clock domain and reset rst, active high.
module mid_props (
  input wire logic        sys_clk,
  input wire logic        rst,
  input wire logic        op_valid,
  input wire logic        op_ready,
  input wire logic [7:0]  opcode,
  input wire logic [7:0]  op_arg,
  input wire logic [7:0]  rom_data,
  input wire logic [3:0]  acc_in,
  input wire logic        acc_we,
  input wire logic [3:0]  acc_out,
  input wire logic [3:0]  high_address_register,
  input wire logic [3:0]  low_address_register,
  input wire logic [11:0] table_pointer,
  input wire logic        status_flag,
  input wire logic        mem_we,
  input wire logic [7:0]  mem_addr,
  input wire logic [3:0]  mem_wdata
);
  timeunit 1ns;
  timeprecision 1ns;
  wire tk = op_valid && op_ready;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  AST_LD_HIGH:
    assert property (tk && opcode[7:4] == 4'hc |=>
      high_address_register == $past(opcode[3:0])) else $error("high load");
  AST_LD_LOW:
    assert property (tk && opcode[7:4] == 4'he |=>
      low_address_register == $past(opcode[3:0])) else $error("low load");
  AST_TBL_LOW:
    assert property (tk && opcode == 8'h33 |=> !op_ready ##1 acc_we &&
      acc_out == $past(rom_data[3:0], 2) && status_flag) else $error("tbl lo");
  AST_TBL_HIGH:
    assert property (tk && opcode == 8'h32 |=> ##1 acc_we &&
      acc_out == $past(rom_data[7:4], 2) &&
      table_pointer == $past(table_pointer, 2) + 12'h1) else $error("tbl hi");
  AST_ST_IND:
    assert property (tk && opcode == 8'h0f |=> mem_we &&
      mem_wdata == $past(acc_in) && mem_addr == {$past(high_address_register),
      $past(low_address_register)}) else $error("store indirect");
  AST_ST_INC:
    assert property (tk && opcode == 8'h1a |=> mem_we &&
      low_address_register == $past(low_address_register) + 4'h1 &&
      status_flag == ($past(low_address_register) != 4'hf)) else $error("inc");
  AST_ST_DIR:
    assert property (tk && opcode == 8'h3f |=> ##1 mem_we &&
      mem_addr == $past(op_arg, 2) && status_flag) else $error("direct");
  AST_ST_IMM:
    assert property (tk && opcode[7:4] == 4'hf |=> mem_we &&
      mem_wdata == $past(opcode[3:0]) &&
      low_address_register == $past(low_address_register) + 4'h1)
      else $error("store immediate");
  AST_ST_DEC:
    assert property (tk && opcode == 8'h1b |=>
      low_address_register == $past(low_address_register) - 4'h1 &&
      status_flag == ($past(low_address_register) != 4'h0)) else $error("dec");
endmodule // mid_props

/* tb/mid_mem_model.sv */
// Data memory beside the decoder: stores a nibble on each write pulse.
// Assumes writes are qualified by mem_we alone, on the rising edge.
module mid_mem_model (
  input wire logic       sys_clk,
  input wire logic       mem_we,
  input wire logic [7:0] mem_addr,
  input wire logic [3:0] mem_wdata
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] mem [256];
  always @(posedge sys_clk) begin
    if (mem_we)
      mem[mem_addr] <= mem_wdata;
  end
endmodule // mid_mem_model

/* tb/mid_decoder_test.sv */
// Self-checking bench for the move decoder with a data memory model.
// The bench plays the fetch unit: opcode, second byte and table word together.
module mid_decoder_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic        sys_clk, rst, op_valid, op_ready, op_done, acc_we;
  logic        zero_flag, status_flag, mem_we;
  logic [7:0]  opcode, op_arg, rom_data, mem_addr;
  logic [3:0]  acc_in, acc_out, high_address_register, low_address_register;
  logic [3:0]  mem_wdata;
  logic [11:0] table_pointer;
  int          num_errors, samples_checked;
  mid_decoder u_dut (.sys_clk, .rst, .op_valid, .opcode, .op_arg, .rom_data,
    .acc_in, .op_ready, .op_done, .acc_we, .acc_out, .high_address_register,
    .low_address_register, .table_pointer, .zero_flag, .status_flag, .mem_we,
    .mem_addr, .mem_wdata);
  mid_mem_model u_mem (.sys_clk, .mem_we, .mem_addr, .mem_wdata);
  task automatic chk(input logic [11:0] seen, exp);
    samples_checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("mismatch at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask
  // The request is held until op_ready is sampled high, or released after at most 8 cycles.
  task automatic op(input logic [7:0] oc, arg, rom, input logic [3:0] acc);
    int n;
    @(posedge sys_clk);
    op_valid <= 1'b1;
    opcode <= oc;
    op_arg <= arg;
    rom_data <= rom;
    acc_in <= acc;
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (op_ready !== 1'b1 && n < 8);
    op_valid <= 1'b0;
    #1;
    while (op_done !== 1'b1 && n < 12) begin
      @(posedge sys_clk);
      #1;
      n++;
    end
    chk(op_done, 1'b1);
  endtask
  task automatic st(input logic [7:0] oc, arg, addr, input logic [3:0] acc, v);
    op(oc, arg, 8'h00, acc);
    @(posedge sys_clk);
    #1;
    chk(u_mem.mem[addr], v);
  endtask
  task automatic t_loads;
    op(8'hc5, 8'h00, 8'h00, 4'h0);
    chk(high_address_register, 4'h5);
    op(8'he9, 8'h00, 8'h00, 4'h0);
    chk(low_address_register, 4'h9);
    op(8'he0, 8'h00, 8'h00, 4'h0);
    chk(low_address_register, 4'h0);
  endtask
  task automatic t_table;
    op(8'h33, 8'h00, 8'h9c, 4'h0);
    chk({acc_out, zero_flag, status_flag}, 6'h31);
    op(8'h32, 8'h00, 8'h06, 4'h0);
    chk({acc_out, zero_flag}, 5'h01);
    chk(table_pointer, 12'h001);
  endtask
  task automatic t_store;
    op(8'hc3, 8'h00, 8'h00, 4'h0);
    op(8'hef, 8'h00, 8'h00, 4'h0);
    st(8'h1a, 8'h00, 8'h3f, 4'h7, 4'h7);
    chk({low_address_register, zero_flag, status_flag}, 6'h02);
    st(8'h1b, 8'h00, 8'h30, 4'h2, 4'h2);
    chk({low_address_register, zero_flag, status_flag}, 6'h3c);
    st(8'h0f, 8'h00, 8'h3f, 4'h4, 4'h4);
    st(8'hf9, 8'h00, 8'h3f, 4'h0, 4'h9);
    chk(low_address_register, 4'h0);
    st(8'h3f, 8'h5a, 8'h5a, 4'h6, 4'h6);
    chk(status_flag, 1'b1);
  endtask
  // Mid-run reset: registers and flags return to idle values, pointer too.
  task automatic t_reset;
    @(posedge sys_clk);
    rst <= 1'b1;
    repeat (2) @(posedge sys_clk);
    rst <= 1'b0;
    #1;
    chk({high_address_register, low_address_register}, 8'h00);
    chk({op_ready, zero_flag, status_flag, mem_we}, 4'h8);
    op(8'h32, 8'h00, 8'h50, 4'h0);
    chk(acc_out, 4'h5);
    chk(table_pointer, 12'h001);
  endtask
  task automatic stop_test;
    $display("checks %0d, mismatches %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  initial begin
    rst = 1'b1;
    {op_valid, opcode, op_arg, rom_data, acc_in} = '0;
    num_errors = 0;
    samples_checked = 0;
    repeat (10) @(posedge sys_clk);
    rst <= 1'b0;
    t_loads;
    t_table;
    t_store;
    t_reset;
    stop_test;
  end
  // About 13 operations of a few cycles each; this leaves wide margin.
  initial begin
    #20000;
    num_errors++;
    stop_test;
  end
endmodule // mid_decoder_test
bind mid_decoder mid_props u_props (.sys_clk, .rst, .op_valid, .op_ready,
  .opcode, .op_arg, .rom_data, .acc_in, .acc_we, .acc_out,
  .high_address_register, .low_address_register, .table_pointer,
  .status_flag, .mem_we, .mem_addr, .mem_wdata);
